//--- core/fire_point_status_regs.sv
// read-only holding register bank for point device types and zone/circuit status
`timescale 1ns/100ps
`include "fp_status_defs.svh"

module fire_point_status_regs (
   input  wire logic                      mclk_i,        // 250 MHz clock
   input  wire logic                      rst_b_i,       // sync reset, active low
   // client read port
   input  wire logic                      rd_en_i,       // read request pulse
   input  wire logic [15:0]               rd_addr_i,     // holding register number
   output logic      [15:0]               rd_data_o,     // read data
   output logic                           rd_valid_o,    // read answer pulse
   output logic                           rd_err_o,      // unmapped address pulse
   // panel side device-type update
   input  wire logic                      dt_wr_i,       // device-type write pulse
   input  wire logic [4:0]                dt_block_i,    // block 0..19, loop*2+module
   input  wire logic [7:0]                dt_point_i,    // point 1..200 within block
   input  wire logic [7:0]                dt_code_i,     // device-type code
   output logic                           dt_wr_err_o,   // last dt write was out of range
   // panel side zone/circuit update
   input  wire logic                      zs_wr_i,       // status write pulse
   input  wire logic [11:0]               zs_index_i,    // entry 0..3205
   input  wire logic                      ack_block_i,   // non-fire events acked
   input  wire logic                      prealarm_i,    // prealarm
   input  wire logic                      trouble_i,     // trouble
   input  wire logic                      enabled_i,     // enabled
   input  wire logic                      disabled_i,    // disabled
   input  wire logic                      ack_fire_i,    // fire alarm acked
   input  wire fp_status_pkg::cond_class_e cond_i,       // condition class
   input  wire logic [7:0]                event_code_i,  // active event code
   input  wire logic                      present_i      // programmed in panel
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   // device-type array
   logic [15:0] dt_mem [0:`DT_REG_COUNT-1];
   // zone and panel-circuit words share one array
   logic [15:0] zs_mem [0:`ZS_REG_COUNT-1];
   // written-since-reset marks, the arrays themselves have no reset
   logic [`DT_REG_COUNT-1:0] dt_seen;
   logic [`ZS_REG_COUNT-1:0] zs_seen;

   // registered read port and write status
   fp_status_pkg::bank_state_s state;
   fp_status_pkg::bank_state_s next_state;

   // panel-side write decode
   logic [15:0] zs_word;
   logic [10:0] dt_index;
   logic        dt_in_range;
   logic        dt_odd;
   logic [7:0]  dt_pm1;
   logic        zs_in_range;

   // client read decode
   logic        rd_dt_hit;
   logic        rd_zs_hit;
   logic        rd_pc_hit;
   logic [10:0] rd_dt_idx;
   logic [11:0] rd_zs_idx;
   logic [15:0] rd_dt_diff;
   logic [15:0] rd_zs_diff;

   // ----------------------------------------------------------------
   // status word encoder
   // ----------------------------------------------------------------
   status_word_encode u_encode (
      .ack_block_i  (ack_block_i),
      .prealarm_i   (prealarm_i),
      .trouble_i    (trouble_i),
      .enabled_i    (enabled_i),
      .disabled_i   (disabled_i),
      .ack_fire_i   (ack_fire_i),
      .cond_i       (cond_i),
      .event_code_i (event_code_i),
      .present_i    (present_i),
      .word_o       (zs_word)
   );

   // ----------------------------------------------------------------
   // write address mapping
   // ----------------------------------------------------------------
   // block base plus pair index
   always_comb begin
      dt_pm1      = dt_point_i - 8'h01;
      dt_odd      = dt_point_i[0];
      // register is block times block size plus half of point minus one
      dt_index    = 11'(dt_block_i * `DT_BLOCK_SIZE) + {4'h0, dt_pm1[7:1]};
      // nothing past loop 10 modules
      // point 0 and points past the block maximum are refused as well
      dt_in_range = (dt_block_i < `DT_BLOCK_COUNT) && (dt_point_i != 8'h00)
                    && (dt_point_i <= `DT_POINT_MAX);
      // entries past the last panel circuit are dropped
      zs_in_range = (zs_index_i < `ZS_REG_COUNT);
   end

   // ----------------------------------------------------------------
   // panel-side writes
   // ----------------------------------------------------------------
   // panel-side writes into the arrays
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         dt_seen <= '0;
         zs_seen <= '0;
      end else begin
         if (dt_wr_i && dt_in_range) begin
            dt_seen[dt_index] <= 1'b1;
            // first write of a pair zeroes the other byte
            if (!dt_seen[dt_index]) begin
               dt_mem[dt_index] <= dt_odd ? {8'h00, dt_code_i} : {dt_code_i, 8'h00};
            end else if (dt_odd) begin
               dt_mem[dt_index][7:0] <= dt_code_i;
            end else begin
               dt_mem[dt_index][15:8] <= dt_code_i;
            end
         end
         // panel circuits share the zone array
         if (zs_wr_i && zs_in_range) begin
            zs_seen[zs_index_i] <= 1'b1;
            zs_mem[zs_index_i]  <= zs_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   always_comb begin
      // index offsets into each array
      rd_dt_diff = rd_addr_i - `DT_FIRST_ADDR;
      rd_zs_diff = rd_addr_i - `ZS_FIRST_ADDR;
      rd_dt_idx  = rd_dt_diff[10:0];
      rd_zs_idx  = rd_zs_diff[11:0];
      // hit windows on the full register number
      rd_dt_hit  = (rd_addr_i >= `DT_FIRST_ADDR) && (rd_addr_i <= `DT_LAST_ADDR);
      rd_zs_hit  = (rd_addr_i >= `ZS_FIRST_ADDR) && (rd_addr_i < `PC_FIRST_ADDR);
      // panel circuits right after the zones
      rd_pc_hit  = (rd_addr_i >= `PC_FIRST_ADDR) && (rd_addr_i <= `ZS_LAST_ADDR);
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   // next state of the read port
   // reads leave stored values untouched
   always_comb begin
      next_state          = state;
      next_state.rd_valid = 1'b0;
      next_state.rd_err   = 1'b0;
      // write status follows every device-type write
      if (dt_wr_i) begin
         next_state.dt_wr_err = ~dt_in_range;
      end
      // one answer per taken read, error on unmapped
      case (state.rd_state)
         fp_status_pkg::RD_IDLE,
         fp_status_pkg::RD_HIT,
         fp_status_pkg::RD_MISS: begin
            if (rd_en_i) begin
               next_state.rd_valid = 1'b1;
               if (rd_dt_hit) begin
                  next_state.rd_state = fp_status_pkg::RD_HIT;
                  next_state.rd_data  = dt_seen[rd_dt_idx] ? dt_mem[rd_dt_idx] : `DT_UNWRITTEN;
               end else if (rd_zs_hit || rd_pc_hit) begin
                  next_state.rd_state = fp_status_pkg::RD_HIT;
                  next_state.rd_data  = zs_seen[rd_zs_idx] ? zs_mem[rd_zs_idx] : `ZS_UNWRITTEN;
               end else begin
                  next_state.rd_state = fp_status_pkg::RD_MISS;
                  next_state.rd_data  = `RD_UNMAPPED;
                  next_state.rd_err   = 1'b1;
               end
            end else begin
               next_state.rd_state = fp_status_pkg::RD_IDLE;
            end
         end
         default: begin
            next_state.rd_state = fp_status_pkg::RD_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // state register
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state.rd_state  <= fp_status_pkg::RD_IDLE;
         state.rd_data   <= `RD_UNMAPPED;
         state.rd_valid  <= 1'b0;
         state.rd_err    <= 1'b0;
         state.dt_wr_err <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // outputs straight from flops
   // ----------------------------------------------------------------
   assign rd_data_o   = state.rd_data;
   assign rd_valid_o  = state.rd_valid;
   assign rd_err_o    = state.rd_err;
   assign dt_wr_err_o = state.dt_wr_err;

endmodule

//--- include/fp_status_defs.svh
// address map, field positions and fill values of the fire point status bank
`ifndef FP_STATUS_DEFS_SVH
`define FP_STATUS_DEFS_SVH

// ----------------------------------------------------------------
// device-type register bank
// ----------------------------------------------------------------
`define DT_FIRST_ADDR    16'hABE1
`define DT_LAST_ADDR     16'hB3B0
`define DT_REG_COUNT     11'h7D0
`define DT_BLOCK_SIZE    11'h064
`define DT_BLOCK_COUNT   5'h14
`define DT_POINT_MAX     8'hC8

// ----------------------------------------------------------------
// zone and panel-circuit status bank
// ----------------------------------------------------------------
`define ZS_FIRST_ADDR    16'hB3B1
`define ZS_LAST_ADDR     16'hC036
`define ZS_REG_COUNT     12'hC86
`define PC_FIRST_ADDR    16'hBFD7
`define PC_PER_PANEL     4'h8

// ----------------------------------------------------------------
// status word field positions
// ----------------------------------------------------------------
`define SW_ACK_BLOCK_BIT 15
`define SW_PREALARM_BIT  14
`define SW_TROUBLE_BIT   13
`define SW_NOT_ACTIVE_FLAG_BIT  12
`define SW_ACTIVE_BIT    11
`define SW_ENABLED_BIT   10
`define SW_DISABLED_BIT  9
`define SW_ACK_FIRE_BIT  8

// ----------------------------------------------------------------
// lower-byte encodings and read defaults
// ----------------------------------------------------------------
`define SW_CODE_ABSENT   8'hFF
`define SW_CODE_IDLE     8'h00
`define DT_UNWRITTEN     16'h0000
`define ZS_UNWRITTEN     16'h10FF
`define RD_UNMAPPED      16'h0000

`endif

//--- include/fp_status_pkg.sv
// types shared by the fire point status bank
package fp_status_pkg;

   // condition class reported by the panel for a zone or circuit
   typedef enum logic [2:0] {
      COND_NONE        = 3'b000,
      COND_FIRE        = 3'b001,
      COND_SECURITY    = 3'b010,
      COND_CRITICAL    = 3'b011,
      COND_MEDICAL     = 3'b100,
      COND_MASS_NOTIFY = 3'b101,
      COND_SUPERVISORY = 3'b110,
      COND_OTHER       = 3'b111
   } cond_class_e;

   // read port state
   typedef enum logic [1:0] {
      RD_IDLE  = 2'b00,
      RD_HIT   = 2'b01,
      RD_MISS  = 2'b10
   } rd_state_e;

   typedef struct packed {
      rd_state_e    rd_state;
      logic [15:0]  rd_data;
      logic         rd_valid;
      logic         rd_err;
      logic         dt_wr_err;
   } bank_state_s;

endpackage

//--- core/status_word_encode.sv
// builds one zone or panel-circuit status word from panel-side conditions
`timescale 1ns/100ps
`include "fp_status_defs.svh"

module status_word_encode (
   input  wire logic                      ack_block_i,  // non-fire events acknowledged
   input  wire logic                      prealarm_i,   // prealarm condition
   input  wire logic                      trouble_i,    // trouble condition
   input  wire logic                      enabled_i,    // circuit enabled
   input  wire logic                      disabled_i,   // circuit disabled
   input  wire logic                      ack_fire_i,   // fire alarm acknowledged
   input  wire fp_status_pkg::cond_class_e cond_i,      // current condition class
   input  wire logic [7:0]                event_code_i, // active event code
   input  wire logic                      present_i,    // programmed in panel
   output logic      [15:0]               word_o        // encoded status word
);

   logic active;

   // alarm classes that count as active
   // active class set
   always_comb begin
      case (cond_i)
         fp_status_pkg::COND_FIRE,
         fp_status_pkg::COND_SECURITY,
         fp_status_pkg::COND_CRITICAL,
         fp_status_pkg::COND_MEDICAL,
         fp_status_pkg::COND_MASS_NOTIFY,
         fp_status_pkg::COND_SUPERVISORY: active = present_i;
         default:                         active = 1'b0;
      endcase
   end

   // pack flags and lower byte
   always_comb begin
      word_o = 16'h0000;
      word_o[`SW_ACK_BLOCK_BIT] = ack_block_i;
      word_o[`SW_PREALARM_BIT]  = prealarm_i;
      word_o[`SW_TROUBLE_BIT]   = trouble_i;
      word_o[`SW_NOT_ACTIVE_FLAG_BIT]  = ~active;
      word_o[`SW_ACTIVE_BIT]    = active;
      word_o[`SW_ENABLED_BIT]   = enabled_i;
      word_o[`SW_DISABLED_BIT]  = disabled_i;
      word_o[`SW_ACK_FIRE_BIT]  = ack_fire_i;
      if (!present_i) begin
         word_o[7:0] = `SW_CODE_ABSENT;
      end else if (active) begin
         word_o[7:0] = event_code_i;
      end else begin
         word_o[7:0] = `SW_CODE_IDLE;
      end
   end

endmodule

//--- tb/fp_status_props.sv
// concurrent checks on the read port and device-type write status of the bank
`timescale 1ns/100ps
`include "fp_status_defs.svh"

module fp_status_props (
   input  wire logic        mclk_i,      // clock
   input  wire logic        rst_b_i,     // sync reset, active low
   input  wire logic        rd_en_i,     // read request
   input  wire logic [15:0] rd_addr_i,   // register number
   input  wire logic [15:0] rd_data_o,   // read data
   input  wire logic        rd_valid_o,  // answer pulse
   input  wire logic        rd_err_o,    // unmapped pulse
   input  wire logic        dt_wr_i,     // device-type write
   input  wire logic [4:0]  dt_block_i,  // block number
   input  wire logic [7:0]  dt_point_i,  // point number
   input  wire logic        dt_wr_err_o  // write range error
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   logic miss;
   logic zone;
   logic dt_bad;
   // address and write classification
   assign miss   = rd_addr_i < `DT_FIRST_ADDR || rd_addr_i > `ZS_LAST_ADDR;
   assign zone   = rd_addr_i >= `ZS_FIRST_ADDR && rd_addr_i <= `ZS_LAST_ADDR;
   assign dt_bad = dt_block_i > 5'h13 || dt_point_i == 8'h00 || dt_point_i > 8'hC8;

   chk_read_answer: assert property (rd_en_i |=> rd_valid_o)
      else $error("read not answered next cycle");
   chk_no_stray: assert property (!rd_en_i |=> !rd_valid_o && $stable(rd_data_o))
      else $error("answer or data change without a read");
   chk_unmapped_err: assert property (rd_en_i && miss |=> rd_err_o && rd_data_o == 16'h0000)
      else $error("unmapped read not refused");
   chk_mapped_ok: assert property (rd_en_i && !miss |=> !rd_err_o)
      else $error("mapped read refused");
   chk_flag_pair: assert property (rd_valid_o && $past(zone) |-> rd_data_o[12] != rd_data_o[11])
      else $error("active and not_active_flag flags agree");
   chk_idle_byte: assert property (rd_valid_o && $past(zone) && !rd_data_o[11]
      |-> rd_data_o[7:0] == 8'h00 || rd_data_o[7:0] == 8'hFF)
      else $error("idle lower byte not 00 or FF");
   chk_dt_bad: assert property (dt_wr_i && dt_bad |=> dt_wr_err_o)
      else $error("bad device-type write not flagged");
   chk_dt_good: assert property (dt_wr_i && !dt_bad |=> !dt_wr_err_o)
      else $error("good device-type write flagged");
   chk_dt_err_holds: assert property (!dt_wr_i |=> $stable(dt_wr_err_o))
      else $error("write error changed without a write");
endmodule

bind fire_point_status_regs fp_status_props chk (.mclk_i, .rst_b_i, .rd_en_i, .rd_addr_i, .rd_data_o,
   .rd_valid_o, .rd_err_o, .dt_wr_i, .dt_block_i, .dt_point_i, .dt_wr_err_o);

//--- tb/holding_reg_client.sv
// client model that reads holding registers one word at a time
`timescale 1ns/100ps

module holding_reg_client (
   input  wire logic        clk_i,    // clock
   input  wire logic [15:0] data_i,   // read data
   input  wire logic        valid_i,  // answer pulse
   input  wire logic        err_i,    // unmapped pulse
   output logic             rd_en_o,  // read request
   output logic [15:0]      addr_o    // register number
);
   initial begin
      rd_en_o = 1'b0;
      addr_o  = 16'h5A5A;
   end
   task automatic read(input logic [15:0] a, output logic [15:0] d, output logic e, output logic ok);
      int n;
      @(posedge clk_i);
      #1 rd_en_o = 1'b1;
      addr_o = a;
      @(posedge clk_i);
      #1 rd_en_o = 1'b0;
      addr_o = ~a;  // no stale address once released
      for (n = 0; n < 4 && valid_i !== 1'b1; n++) @(posedge clk_i) #1;
      d  = data_i;
      e  = err_i;
      ok = valid_i === 1'b1;
   endtask
endmodule

//--- tb/tb_fire_point_status_register_map.sv
// self-checking bench of the fire point status register bank
`timescale 1ns/100ps
`include "fp_status_defs.svh"

module tb_fire_point_status_register_map;
   logic mclk_i, rst_b_i, rd_en_i, rd_valid_o, rd_err_o, dt_wr_i, dt_wr_err_o, zs_wr_i, present_i;
   logic [15:0] rd_addr_i, rd_data_o, exp_w;
   logic [4:0] dt_block_i;
   logic [7:0] dt_point_i, dt_code_i, event_code_i;
   logic [11:0] zs_index_i;
   logic [5:0] fl;
   fp_status_pkg::cond_class_e cond_i;
   logic [15:0] dt_sh [2000];
   logic [15:0] bad [4] = '{16'hABE0, 16'hC037, 16'h0000, 16'hFFFF};
   int num_errors, n_checks, seed, b, p;

   fire_point_status_regs uut (.mclk_i, .rst_b_i, .rd_en_i, .rd_addr_i, .rd_data_o, .rd_valid_o, .rd_err_o,
      .dt_wr_i, .dt_block_i, .dt_point_i, .dt_code_i, .dt_wr_err_o, .zs_wr_i, .zs_index_i,
      .ack_block_i(fl[5]), .prealarm_i(fl[4]), .trouble_i(fl[3]), .enabled_i(fl[2]), .disabled_i(fl[1]),
      .ack_fire_i(fl[0]), .cond_i, .event_code_i, .present_i);
   holding_reg_client client (.clk_i(mclk_i), .data_i(rd_data_o), .valid_i(rd_valid_o), .err_i(rd_err_o),
      .rd_en_o(rd_en_i), .addr_o(rd_addr_i));

   // clock generation
   initial begin
      mclk_i = 1'b0;
      forever #2 mclk_i = ~mclk_i;
   end

   // expected zone word from panel-side inputs
   function automatic logic [15:0] zenc(input logic [5:0] f, input logic [2:0] c, input logic [7:0] code,
                                        input logic pr);
      logic act;
      act = pr && c != 3'h0 && c != 3'h7;
      return {f[5:3], ~act, act, f[2:0], !pr ? 8'hFF : (act ? code : 8'h00)};
   endfunction

   task automatic check(input logic [15:0] got, input logic [15:0] x);
      n_checks++;
      if (got !== x) begin
         num_errors++;
         $display("unexpected at %0t: got %h wanted %h", $time, got, x);
      end
   endtask

   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one read compared against data and error flag
   task automatic rdx(input logic [15:0] a, input logic [15:0] x, input logic xe);
      logic [15:0] d;
      logic e, ok;
      client.read(a, d, e, ok);
      if (ok !== 1'b1) begin
         num_errors++;
         $display("unexpected at %0t: no answer", $time);
         test_done();
      end else begin
         check(d, x);
         check({15'h0, e}, {15'h0, xe});
      end
   endtask

   task automatic dtw(input int bb, input int pp, input logic [7:0] c);
      @(posedge mclk_i);
      #1 dt_wr_i = 1'b1;
      dt_block_i = 5'(bb);
      dt_point_i = 8'(pp);
      dt_code_i  = c;
      @(posedge mclk_i);
      #1 dt_wr_i = 1'b0;
      if (bb < 20 && pp > 0 && pp <= 200) begin
         if (pp % 2 == 1) dt_sh[bb * 100 + (pp - 1) / 2][7:0] = c;
         else dt_sh[bb * 100 + (pp - 1) / 2][15:8] = c;
      end
   endtask

   // watchdog
   initial begin
      #200000;
      num_errors++;
      $display("unexpected at %0t: run hung", $time);
      test_done();
   end

   // main sequence
   initial begin
      {rst_b_i, dt_wr_i, zs_wr_i, present_i, dt_block_i, dt_point_i, dt_code_i, event_code_i} = '0;
      {zs_index_i, fl} = '0;
      cond_i = fp_status_pkg::COND_NONE;
      seed = 41;
      foreach (dt_sh[i]) dt_sh[i] = 16'h0000;
      repeat (4) @(posedge mclk_i);
      #1 rst_b_i = 1'b1;
      rdx(`DT_FIRST_ADDR, `DT_UNWRITTEN, 1'b0);
      rdx(`DT_LAST_ADDR, `DT_UNWRITTEN, 1'b0);
      rdx(`ZS_LAST_ADDR, `ZS_UNWRITTEN, 1'b0);
      foreach (bad[i]) rdx(bad[i], 16'h0000, 1'b1);
      dtw(0, 2, 8'h12);
      dtw(0, 1, 8'h34);
      rdx(16'hABE1, 16'h1234, 1'b0);
      rdx(16'hABE1, 16'h1234, 1'b0);
      dtw(19, 200, 8'hA5);
      rdx(`DT_LAST_ADDR, 16'hA500, 1'b0);
      dtw(20, 1, 8'h77);
      check({15'h0, dt_wr_err_o}, 16'h0001);
      for (int k = 0; k < 10; k++) begin
         b = $unsigned($random(seed)) % 20;
         p = 1 + $unsigned($random(seed)) % 200;
         dtw(b, p, 8'($random(seed)));
         rdx(16'(`DT_FIRST_ADDR + b * 100 + (p - 1) / 2), dt_sh[b * 100 + (p - 1) / 2], 1'b0);
      end
      check({15'h0, dt_wr_err_o}, 16'h0000);
      for (int k = 0; k < 10; k++) begin
         @(posedge mclk_i);
         #1 zs_wr_i = 1'b1;
         zs_index_i = k == 8 ? 12'hC26 : (k == 9 ? 12'hC85 : 12'($unsigned($random(seed)) % 3206));
         fl = 6'($random(seed));
         cond_i = fp_status_pkg::cond_class_e'(3'(k));
         event_code_i = 8'($random(seed)) | 8'h01;
         present_i = k != 9;
         exp_w = zenc(fl, 3'(k), event_code_i, present_i);
         @(posedge mclk_i);
         #1 zs_wr_i = 1'b0;
         rdx(`ZS_FIRST_ADDR + 16'(zs_index_i), exp_w, 1'b0);
      end
      // mid-run reset forgets every write and clears the write error
      dtw(20, 1, 8'h55);
      check({15'h0, dt_wr_err_o}, 16'h0001);
      @(posedge mclk_i);
      #1 rst_b_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1 rst_b_i = 1'b1;
      check({15'h0, dt_wr_err_o}, 16'h0000);
      check(rd_data_o, `RD_UNMAPPED);
      rdx(`DT_FIRST_ADDR, `DT_UNWRITTEN, 1'b0);
      rdx(`PC_FIRST_ADDR, `ZS_UNWRITTEN, 1'b0);
      test_done();
   end
endmodule
